// ---- src/vdac_map.vh ----
`ifndef VDAC_MAP_VH
`define VDAC_MAP_VH
// colour word width
`define VDAC_PIX_W       8
// converter codes
`define VDAC_FULL_CODE   8'hff
`define VDAC_BLANK_CODE  8'h00
// control reset values
`define VDAC_BLANK_N_RST 1'b0
`define VDAC_SYNC_N_RST  1'b0
`define VDAC_FULL_RST    1'b0
// pipeline depth, input stage plus converter stage
`define VDAC_PIPE_DEPTH  2
// buffer word: r, g, b, sync_n, blank_n, full
`define VDAC_WORD_W      27
`endif

// ---- src/vdac_buf2.v ----
`timescale 1ns/10ps
// two-entry skid buffer; an entry pops only when the drain side is ready
module vdac_buf2 #(
	parameter WIDTH = 27
) (
	input  wire             mclk_in,
	input  wire             reset_in,
	input  wire             s_valid_in,
	output wire             s_ready_out,
	input  wire [WIDTH-1:0] s_data_in,
	output wire             m_valid_out,
	input  wire             m_ready_in,
	output wire [WIDTH-1:0] m_data_out
);
	reg [WIDTH-1:0] d0_r;
	reg [WIDTH-1:0] d1_r;
	reg [1:0]       cnt_r;
	wire            push;
	wire            pop;

	assign s_ready_out = (cnt_r != 2'd2);
	assign m_valid_out = (cnt_r != 2'd0);
	assign m_data_out  = d0_r;
	assign push        = s_valid_in && s_ready_out;
	assign pop         = m_valid_out && m_ready_in;

	// d0 is the head; d1 holds the second word only while full
	always @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			cnt_r <= 2'd0;
			d0_r  <= {WIDTH{1'b0}};
			d1_r  <= {WIDTH{1'b0}};
		end
		else
		begin
			case ({push, pop})
				2'b10:
				begin
					if (cnt_r == 2'd0)
						d0_r <= s_data_in;
					else
						d1_r <= s_data_in;
					cnt_r <= cnt_r + 2'd1;
				end
				2'b01:
				begin
					d0_r  <= d1_r;
					cnt_r <= cnt_r - 2'd1;
				end
				2'b11:
				begin
					if (cnt_r == 2'd1)
						d0_r <= s_data_in;
					else
					begin
						d0_r <= d1_r;
						d1_r <= s_data_in;
					end
				end
				default:
					cnt_r <= cnt_r;
			endcase
		end
	end
endmodule

// ---- src/vdac_input_ctrl.v ----
// Behaviour
// [R01] every rising clock edge captures red, green and blue pixel words; the code skips capture while the input stage holds on a full buffer
// [R02] registered sync low turns the tip current source off, high turns it on
// [R03] sync is captured with pixels and delayed through identical stages
// [R04] controller asserts sync only during blanking; sync overrides nothing
// [R05] registered blanking low forces every converter output to blanking level
// [R06] blanking captured on rising edge with two-stage latency like data
// [R07] registered full-scale force high drives all outputs to full-scale code
// [R08] blanking wins over full-scale force when both are active
// [R09] full-scale force captured on rising edge with two-stage latency
// [R10] power-down disables current sources and all digital processing
// [R11] power-down keeps input and converter register contents unchanged
// [R12] power-down acts at once, without waiting for a clock edge
// [R13] no register loads during power-down; capture resumes first edge after
// [R14] output select priority: blanking, then full-scale, then pipelined pixel
`timescale 1ns/10ps
`include "vdac_map.vh"
module vdac_input_ctrl #(
	parameter PIX_W = `VDAC_PIX_W
) (
	input  wire             mclk_in,
	input  wire             reset_in,
	input  wire [PIX_W-1:0] red_pixel_word_in,
	input  wire [PIX_W-1:0] green_pixel_word_in,
	input  wire [PIX_W-1:0] blue_pixel_word_in,
	input  wire             sync_n_in,
	input  wire             blank_n_in,
	input  wire             full_scale_in,
	input  wire             power_down_in,
	input  wire             conv_ready_in,
	output wire             pix_ready_out,
	output wire             conv_valid_out,
	output reg  [PIX_W-1:0] red_current_out,
	output reg  [PIX_W-1:0] green_current_out,
	output reg  [PIX_W-1:0] blue_current_out,
	output reg              tip_current_out,
	output reg              red_enable_out,
	output reg              green_enable_out,
	output reg              blue_enable_out,
	output wire             power_down_out
);
	localparam WW = 3 * PIX_W + 3;

	// input register stage
	reg [PIX_W-1:0] in_red_r;
	reg [PIX_W-1:0] in_green_r;
	reg [PIX_W-1:0] in_blue_r;
	reg             in_sync_n_r;
	reg             in_blank_n_r;
	reg             in_full_r;
	reg             in_valid_r;
	// converter register stage
	reg [PIX_W-1:0] cv_red_r;
	reg [PIX_W-1:0] cv_green_r;
	reg [PIX_W-1:0] cv_blue_r;
	reg             cv_sync_n_r;
	reg             cv_blank_n_r;
	reg             cv_full_r;

	wire            buf_s_ready;
	wire            buf_m_valid;
	wire [WW-1:0]   buf_m_data;
	wire            run;
	wire            hold_in;

	// power-down stalls the whole pipe; no clock edge is needed for it to act
	assign run = !power_down_in; // [R12]
	assign power_down_out = power_down_in; // [R10]
	// input stage holds while the buffer is full so no word is lost
	assign hold_in = in_valid_r && !buf_s_ready;
	assign pix_ready_out = run && !hold_in;

	// stage one: capture pixels and controls together on the rising edge
	always @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			in_red_r     <= {PIX_W{1'b0}};
			in_green_r   <= {PIX_W{1'b0}};
			in_blue_r    <= {PIX_W{1'b0}};
			in_sync_n_r  <= `VDAC_SYNC_N_RST;
			in_blank_n_r <= `VDAC_BLANK_N_RST;
			in_full_r    <= `VDAC_FULL_RST;
			in_valid_r   <= 1'b0;
		end
		else if (run && !hold_in) // [R11] [R13]
		begin
			in_red_r     <= red_pixel_word_in; // [R01]
			in_green_r   <= green_pixel_word_in; // [R01]
			in_blue_r    <= blue_pixel_word_in; // [R01]
			in_sync_n_r  <= sync_n_in; // [R03]
			in_blank_n_r <= blank_n_in; // [R06]
			in_full_r    <= full_scale_in; // [R09]
			in_valid_r   <= 1'b1;
		end
	end

	// skid buffer between stages; only popped while running
	vdac_buf2 #(
		.WIDTH (WW)
	) u_buf (
		.mclk_in     (mclk_in),
		.reset_in    (reset_in),
		.s_valid_in  (in_valid_r && run),
		.s_ready_out (buf_s_ready),
		.s_data_in   ({in_red_r, in_green_r, in_blue_r,
			in_sync_n_r, in_blank_n_r, in_full_r}),
		.m_valid_out (buf_m_valid),
		.m_ready_in  (conv_ready_in && run),
		.m_data_out  (buf_m_data)
	);

	assign conv_valid_out = buf_m_valid && run;

	// stage two: every field gets the same second delay, sync included
	always @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			cv_red_r     <= {PIX_W{1'b0}};
			cv_green_r   <= {PIX_W{1'b0}};
			cv_blue_r    <= {PIX_W{1'b0}};
			cv_sync_n_r  <= `VDAC_SYNC_N_RST;
			cv_blank_n_r <= `VDAC_BLANK_N_RST;
			cv_full_r    <= `VDAC_FULL_RST;
		end
		else if (run && buf_m_valid && conv_ready_in) // [R11] [R13]
		begin
			cv_red_r     <= buf_m_data[WW-1 -: PIX_W];
			cv_green_r   <= buf_m_data[WW-1-PIX_W -: PIX_W];
			cv_blue_r    <= buf_m_data[WW-1-2*PIX_W -: PIX_W];
			cv_sync_n_r  <= buf_m_data[2]; // [R03]
			cv_blank_n_r <= buf_m_data[1]; // [R06]
			cv_full_r    <= buf_m_data[0]; // [R09]
		end
	end

	// output select; sync only gates its own source and touches no colour
	always @*
	begin
		if (!cv_blank_n_r) // [R05] [R08] [R14]
		begin
			red_current_out   = `VDAC_BLANK_CODE;
			green_current_out = `VDAC_BLANK_CODE;
			blue_current_out  = `VDAC_BLANK_CODE;
		end
		else if (cv_full_r) // [R07] [R14]
		begin
			red_current_out   = `VDAC_FULL_CODE;
			green_current_out = `VDAC_FULL_CODE;
			blue_current_out  = `VDAC_FULL_CODE;
		end
		else // [R14]
		begin
			red_current_out   = cv_red_r;
			green_current_out = cv_green_r;
			blue_current_out  = cv_blue_r;
		end
		// sources off while powered down, registers keep their content
		tip_current_out  = cv_sync_n_r && run; // [R02] [R04] [R10]
		red_enable_out   = run; // [R10]
		green_enable_out = run;
		blue_enable_out  = run;
	end
endmodule

// ---- test/vdac_ctrl_src.sv ----
`timescale 1ns/10ps
// controller model; sync only ever goes low inside blanking
module vdac_ctrl_src (
	input  wire [26:0] word_in,
	output wire [7:0]  red_out, green_out, blue_out,
	output wire        sync_n_out, blank_n_out, full_out
);
	assign {red_out, green_out, blue_out} = word_in[26:3];
	assign {blank_n_out, full_out} = word_in[1:0];
	assign sync_n_out = word_in[2] | word_in[1];
endmodule

// ---- test/vdac_input_ctrl_asserts.sv ----
`timescale 1ns/10ps
module vdac_input_ctrl_asserts #(parameter PIX_W = 8) (
	input wire mclk_in, reset_in, sync_n_in, blank_n_in, full_scale_in, power_down_in,
	input wire conv_ready_in, tip_current_out, power_down_out,
	input wire red_enable_out, green_enable_out, blue_enable_out,
	input wire [PIX_W-1:0] red_pixel_word_in, green_pixel_word_in, blue_pixel_word_in,
	input wire [PIX_W-1:0] red_current_out, green_current_out, blue_current_out
);
	reg [1:0] run_r;
	reg stall_r;
	wire [3*PIX_W-1:0] pix = {red_pixel_word_in, green_pixel_word_in, blue_pixel_word_in};
	wire [3*PIX_W-1:0] code = {red_current_out, green_current_out, blue_current_out};
	wire [2:0] en = {red_enable_out, green_enable_out, blue_enable_out};
	wire wht = blank_n_in & full_scale_in;
	wire act = blank_n_in & !full_scale_in;
	wire ok = run_r == 2'h3 && !stall_r && !power_down_in;
	// clean-flow edges; a stall leaves backlog in the buffer, so it sticks
	always @(posedge mclk_in)
	begin
		run_r <= (reset_in | power_down_in | !conv_ready_in) ? 2'h0 : run_r + {1'b0, ~&run_r};
		stall_r <= !reset_in & (stall_r | !conv_ready_in);
	end
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);
	property p_blank; ok && !$past(blank_n_in, 3) |-> code == 0; endproperty
	a_blank: assert property (p_blank) else $error("not blank");
	property p_full; ok && $past(wht, 3) |-> &code; endproperty
	a_full: assert property (p_full) else $error("not full");
	property p_pix; ok && $past(act, 3) |-> code == $past(pix, 3); endproperty
	a_pix: assert property (p_pix) else $error("bad pixel");
	property p_tip; ok |-> tip_current_out == $past(sync_n_in, 3); endproperty
	a_tip: assert property (p_tip) else $error("bad tip");
	property p_off; power_down_in |-> en == 3'h0 && !tip_current_out; endproperty
	a_off: assert property (p_off) else $error("not off");
	property p_on; !power_down_in |-> &en; endproperty
	a_on: assert property (p_on) else $error("not on");
	property p_hold; $past(power_down_in) && !$past(reset_in) |-> $stable(code); endproperty
	a_hold: assert property (p_hold) else $error("codes moved");
	property p_pdo; power_down_out == power_down_in; endproperty
	a_pdo: assert property (p_pdo) else $error("bad flag");
	c_blank: cover property (ok && !$past(blank_n_in, 3));
	c_full: cover property (ok && $past(wht, 3));
	c_hold: cover property (power_down_in [*3]);
endmodule
bind vdac_input_ctrl vdac_input_ctrl_asserts #(.PIX_W(PIX_W)) chk_u (.*);

// ---- test/vdac_input_ctrl_bench.sv ----
`timescale 1ns/10ps
module vdac_input_ctrl_bench;
	reg mclk_in = 1'b0, reset_in = 1'b1, power_down_in = 1'b0, conv_ready_in = 1'b1;
	reg [26:0] w = 27'h0;
	reg [26:0] rows [0:4];
	wire [7:0] red_pixel_word_in, green_pixel_word_in, blue_pixel_word_in;
	wire [7:0] red_current_out, green_current_out, blue_current_out;
	wire sync_n_in, blank_n_in, full_scale_in, tip_current_out, pix_ready_out, conv_valid_out;
	wire red_enable_out, green_enable_out, blue_enable_out, power_down_out;
	wire [24:0] seen = {red_current_out, green_current_out, blue_current_out, tip_current_out};
	integer mismatches = 0, n_tests = 0, i;
	// 40 mhz pixel clock
	always #12.5 mclk_in = ~mclk_in;
	vdac_ctrl_src src_u (.word_in(w), .red_out(red_pixel_word_in),
		.green_out(green_pixel_word_in), .blue_out(blue_pixel_word_in),
		.sync_n_out(sync_n_in), .blank_n_out(blank_n_in), .full_out(full_scale_in));
	vdac_input_ctrl dut_u (.*);
	task chk(input [31:0] got, input [31:0] exp);
	begin
		n_tests = n_tests + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("unexpected %0t %h %h", $time, got, exp);
		end
	end
	endtask
	// codes then tip; blank beats full beats pixel
	function [24:0] want(input [26:0] v);
		want = {v[1] ? (v[0] ? 24'hffffff : v[26:3]) : 24'h0, v[2] | v[1]};
	endfunction
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	// watchdog, far past the ~31 cycle run
	initial
	begin
		#5000;
		mismatches = mismatches + 1;
		tally_and_finish;
	end
	initial
	begin
		rows[0] = {24'h123456, 3'b000};
		rows[1] = {24'h9abcde, 3'b101};
		rows[2] = {24'h010203, 3'b111};
		rows[3] = {24'ha55ac3, 3'b110};
		rows[4] = {24'hff007e, 3'b010};
		repeat (10) @(negedge mclk_in);
		chk(seen, 25'h0);
		reset_in = 1'b0;
		// back to back rows, each shows two edges after capture
		for (i = 0; i < 8; i = i + 1)
		begin
			@(negedge mclk_in);
			if (i > 2)
				chk(seen, want(rows[i-3]));
			if (i < 5)
				w = rows[i];
		end
		// sleep: sources drop at once and new words stay out
		power_down_in = 1'b1;
		w = rows[3];
		#1;
		chk({red_enable_out, green_enable_out, blue_enable_out, tip_current_out}, 4'h0);
		chk({power_down_out, conv_valid_out, pix_ready_out}, 3'h4);
		repeat (4) @(negedge mclk_in);
		chk(seen >> 1, want(rows[4]) >> 1);
		power_down_in = 1'b0;
		repeat (3) @(negedge mclk_in);
		chk(seen, want(rows[3]));
		// converter stall: buffer fills, then the input side refuses
		conv_ready_in = 1'b0;
		repeat (6) @(negedge mclk_in);
		chk(pix_ready_out, 1'b0);
		// backlog still offered to the converter while it stalls
		chk({conv_valid_out, power_down_out}, 2'h2);
		tally_and_finish;
	end
endmodule
